// ===== logic/lk_map.svh
// Register offsets, field positions and fixed values of the link extension command unit.
`ifndef LK_MAP_SVH
`define LK_MAP_SVH
`define LK_OFS_CMD    8'h00
`define LK_OFS_ARG    8'h04
`define LK_OFS_SEM    8'h08
`define LK_OFS_MODE   8'h0C
`define LK_OFS_LCFG   8'h10
`define LK_OFS_LSTAT  8'h14
`define LK_OFS_TOP    8'h18
`define LK_OFS_QSTAT  8'h1C
`define LK_SEM_RESET  8'hFF
`define LK_SEM_BUSY   8'h00
`define LK_SEM_DONE   8'hFF
`define LK_SEM_REJECT 8'h01
`define LK_FAULT_ARG  24'h000000
`define LK_CFG_RAW    16
`define LK_CFG_VALID  17
`define LK_ST_STATE   12
`endif

// ===== logic/lk_pkg.sv
// Types shared by the link extension command unit.
`default_nettype none
package lk_pkg;
  // Command codes written by the host.
  typedef enum logic [7:0] {
    LK_CMD_OPEN      = 8'h62,
    LK_CMD_CLOSE     = 8'h6A,
    LK_CMD_REMOTE    = 8'h69,
    LK_CMD_SET_HOLD  = 8'h61,
    LK_CMD_CLR_HOLD  = 8'h60,
    LK_CMD_STOP_I    = 8'h67,
    LK_CMD_STOP_XIDG = 8'h89,
    LK_CMD_STOP_XID0 = 8'h8A
  } lk_cmd_t;
  // Command handler phases.
  typedef enum logic [0:0] {LK_IDLE, LK_EXEC} lk_fsm_t;
  // Per-link protocol state.
  typedef enum logic [1:0] {LK_LS_OFF, LK_LS_NOTEI, LK_LS_RAW} lk_lst_t;
endpackage : lk_pkg
`default_nettype wire

// ===== logic/lk_ext_cmd_unit.sv
// Protocol-extension command handler with APB register access.
//
// How it works
// - Eight command codes decode to open, close, query, hold, release and three stops.
// - Per-link commands take the target link from the argument register.
// - Raw links accept only open, close, set hold, clear hold and stop I.
// - The raw-mode configuration bit picks protocol or raw operation at open.
// - Opening an already active link or DLCI raises a fault with zero argument.
// - Single-chip open stores the pair in a free match entry, else signals full.
// - Expanded mode open writes the link into the external match table.
// - Protocol open sets no-terminal-id state, updates top live index, semaphore FF.
// - Close sets halt, clears acknowledge and transmit bits, keeps active only while I frames are queued.
// - Close deletes the match pair internally or externally and updates top index.
// - Semaphore FF marks acceptance; a queued link finishes close at queue head.
// - Query with a poll outstanding only sets the peer query flag.
// - Query without a poll sends a poll frame and sets both flags.
// - A final response raises peer query done and clears both flags.
// - Set hold forces receive busy through the hold flag, then semaphore FF.
// - Clear hold clears hold and genuine starvation busy, then semaphore FF.
// - Stop I blocks new transmit service and aborts the I frame in flight.
// - Stop I completion interrupt waits until all I frames are acknowledged.
// - Exchange queue stops block service and abort the frame in flight.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lk_map.svh"
module lk_ext_cmd_unit #(
  parameter int NLINK = 16,
  parameter int NMATCH = 16,
  parameter int DW = 13,
  localparam int LW = $clog2(NLINK)
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxFrameValid,
  input  wire logic              rxFrameFinal,
  input  wire logic [LW-1:0]     rxFrameLink,
  input  wire logic              rxStarve,
  input  wire logic [LW-1:0]     rxStarveLink,
  input  wire logic              queueHeadTake,
  input  wire logic [LW-1:0]     queueHeadLink,
  input  wire logic [NLINK-1:0]  iQueued,
  input  wire logic              txIBusy,
  input  wire logic [LW-1:0]     txILink,
  input  wire logic [1:0]        xidBusy,
  input  wire logic [NLINK-1:0]  unackedNone,
  output logic                   pollFrameReq,
  output logic      [LW-1:0]     pollFrameLink,
  output logic                   abortIFrame,
  output logic      [1:0]        abortXidFrame,
  output logic      [NLINK-1:0]  txIStopped,
  output logic      [1:0]        xidStopped,
  output logic      [NLINK-1:0]  localBusy,
  output logic      [NLINK-1:0]  linkActive,
  output logic                   mgmtFaultIrq,
  output logic      [23:0]       mgmtFaultArg,
  output logic                   matchFullIrq,
  output logic                   peerDoneIrq,
  output logic      [LW-1:0]     peerDoneLink,
  output logic                   sendDoneIrq,
  output logic      [LW-1:0]     sendDoneLink,
  output logic                   extMatchWe,
  output logic                   extMatchDel,
  output logic      [DW-1:0]     extMatchDlci,
  output logic      [LW-1:0]     extMatchLink,
  output logic      [LW-1:0]     topLiveLink
);
  import lk_pkg::*;

  // Whole state of the unit.
  typedef struct packed {
    lk_fsm_t                         fsm;
    logic [7:0]                      cmd;
    logic [LW-1:0]                   arg;
    logic [7:0]                      sem;
    logic                            expanded;
    logic [NLINK-1:0][DW-1:0]        cfgDlci;
    logic [NLINK-1:0]                cfgRaw;
    logic [NLINK-1:0]                cfgValid;
    logic [NLINK-1:0]                active;
    logic [NLINK-1:0]                halt;
    logic [NLINK-1:0]                ackBit;
    logic [NLINK-1:0]                txBit;
    logic [NLINK-1:0]                pollOut;
    logic [NLINK-1:0]                peerQ;
    logic [NLINK-1:0]                hold;
    logic [NLINK-1:0]                starve;
    logic [NLINK-1:0]                stopI;
    logic [NLINK-1:0]                waitAck;
    logic [NLINK-1:0]                closing;
    logic [NLINK-1:0]                busyOut;
    lk_lst_t [NLINK-1:0]             lstate;
    logic [NMATCH-1:0]               msValid;
    logic [NMATCH-1:0][DW-1:0]       msDlci;
    logic [NMATCH-1:0][LW-1:0]       msLink;
    logic [LW-1:0]                   topLive;
    logic [1:0]                      xidStop;
    logic [31:0]                     prdata;
    logic                            pready;
    logic                            pslverr;
    logic                            pollReq;
    logic [LW-1:0]                   pollLink;
    logic                            abortI;
    logic [1:0]                      abortXid;
    logic                            faultIrq;
    logic [23:0]                     faultArg;
    logic                            fullIrq;
    logic                            peerIrq;
    logic [LW-1:0]                   peerLink;
    logic                            sendIrq;
    logic [LW-1:0]                   sendLink;
    logic                            extWe;
    logic                            extDel;
    logic [DW-1:0]                   extDlci;
    logic [LW-1:0]                   extLink;
  } lk_state_t;

  lk_state_t     st_q;
  lk_state_t     st_d;
  logic [LW-1:0] tgt;
  logic          dupDlci;
  logic          freeFound;
  logic          doneOk;
  logic          cmdLegal;
  logic [31:0]   rdData;
  logic          rdHit;

  // Highest index of a live link, zero when none is live.
  function automatic logic [LW-1:0] topOf(input logic [NLINK-1:0] v);
    logic [LW-1:0] r;
    r = '0;
    for (int i = 0; i < NLINK; i++) begin
      if (v[i]) begin
        r = LW'(i);
      end
    end
    return r;
  endfunction : topOf

  // True for the commands that name a link in the argument register.
  function automatic logic perLink(input logic [7:0] c);
    return (c == LK_CMD_OPEN) || (c == LK_CMD_CLOSE) || (c == LK_CMD_REMOTE) || (c == LK_CMD_SET_HOLD) ||
           (c == LK_CMD_CLR_HOLD) || (c == LK_CMD_STOP_I);
  endfunction : perLink

  // True for the commands that a raw link may receive.
  function automatic logic rawOk(input logic [7:0] c);
    return perLink(c) && (c != LK_CMD_REMOTE);
  endfunction : rawOk

  // Reads come from the address of the setup phase.
  always_comb begin
    rdData = 32'h0;
    rdHit = 1'h1;
    case (paddr)
      `LK_OFS_CMD:   rdData[7:0] = st_q.cmd;
      `LK_OFS_ARG:   rdData[LW-1:0] = st_q.arg;
      `LK_OFS_SEM:   rdData[7:0] = st_q.sem;
      `LK_OFS_MODE:  rdData[0] = st_q.expanded;
      `LK_OFS_LCFG: begin
        rdData[DW-1:0] = st_q.cfgDlci[st_q.arg];
        rdData[`LK_CFG_RAW] = st_q.cfgRaw[st_q.arg];
        rdData[`LK_CFG_VALID] = st_q.cfgValid[st_q.arg];
      end
      `LK_OFS_LSTAT: begin
        rdData[10:0] = {st_q.closing[st_q.arg], st_q.waitAck[st_q.arg], st_q.stopI[st_q.arg],
                        st_q.starve[st_q.arg], st_q.hold[st_q.arg], st_q.peerQ[st_q.arg],
                        st_q.pollOut[st_q.arg], st_q.txBit[st_q.arg], st_q.ackBit[st_q.arg],
                        st_q.halt[st_q.arg], st_q.active[st_q.arg]};
        rdData[`LK_ST_STATE+:2] = st_q.lstate[st_q.arg];
      end
      `LK_OFS_TOP:   rdData[LW-1:0] = st_q.topLive;
      `LK_OFS_QSTAT: rdData[1:0] = st_q.xidStop;
      default:       rdHit = 1'h0;
    endcase
  end

  // Link lookups used while a command executes.
  always_comb begin
    tgt = st_q.arg;
    dupDlci = 1'h0;
    freeFound = 1'h0;
    for (int i = 0; i < NLINK; i++) begin
      if (st_q.active[i] && (st_q.cfgDlci[i] == st_q.cfgDlci[tgt])) begin
        dupDlci = 1'h1;
      end
    end
    for (int j = 0; j < NMATCH; j++) begin
      if (!st_q.msValid[j]) begin
        freeFound = 1'h1;
      end
    end
    if (st_q.cmd == LK_CMD_OPEN) begin
      cmdLegal = st_q.cfgValid[tgt];
    end else if (perLink(st_q.cmd)) begin
      cmdLegal = st_q.active[tgt] && !st_q.closing[tgt] &&
                 ((st_q.lstate[tgt] != LK_LS_RAW) || rawOk(st_q.cmd));
    end else begin
      cmdLegal = (st_q.cmd == LK_CMD_STOP_XIDG) || (st_q.cmd == LK_CMD_STOP_XID0);
    end
  end

  // Next state: bus slave, link events and the command step.
  always_comb begin
    st_d = st_q;
    doneOk = 1'h0;
    st_d.pollReq = 1'h0;
    st_d.abortI = 1'h0;
    st_d.abortXid = 2'h0;
    st_d.faultIrq = 1'h0;
    st_d.fullIrq = 1'h0;
    st_d.peerIrq = 1'h0;
    st_d.sendIrq = 1'h0;
    st_d.extWe = 1'h0;
    st_d.extDel = 1'h0;
    st_d.pready = 1'h1;
    // Answer data and error are fixed in the setup phase.
    if (psel && !penable) begin
      st_d.prdata = rdHit ? rdData : 32'h0;
      st_d.pslverr = !rdHit;
    end
    // Writes land in the access phase; a command write while busy is dropped.
    if (psel && penable && pwrite && st_q.pready && rdHit) begin
      case (paddr)
        `LK_OFS_CMD: begin
          if (st_q.fsm == LK_IDLE) begin
            st_d.cmd = pwdata[7:0];
            st_d.sem = `LK_SEM_BUSY;
            st_d.fsm = LK_EXEC;
          end
        end
        `LK_OFS_ARG:  st_d.arg = pwdata[LW-1:0];
        `LK_OFS_MODE: st_d.expanded = pwdata[0];
        `LK_OFS_LCFG: begin
          st_d.cfgDlci[st_q.arg] = pwdata[DW-1:0];
          st_d.cfgRaw[st_q.arg] = pwdata[`LK_CFG_RAW];
          st_d.cfgValid[st_q.arg] = pwdata[`LK_CFG_VALID];
        end
        `LK_OFS_QSTAT: st_d.xidStop = st_q.xidStop & ~pwdata[1:0];
        default: ;
      endcase
    end
    // A final response closes the poll on its link.
    if (rxFrameValid && rxFrameFinal && st_q.pollOut[rxFrameLink]) begin
      st_d.peerIrq = 1'h1;
      st_d.peerLink = rxFrameLink;
      st_d.pollOut[rxFrameLink] = 1'h0;
      st_d.peerQ[rxFrameLink] = 1'h0;
    end
    // The transmit task finishes a close when the link leaves its queue head.
    if (queueHeadTake && st_q.closing[queueHeadLink]) begin
      st_d.active[queueHeadLink] = 1'h0;
      st_d.closing[queueHeadLink] = 1'h0;
    end
    // One stop completion per cycle, lowest link first.
    for (int i = 0; i < NLINK; i++) begin
      if (!doneOk && st_q.waitAck[i] && unackedNone[i]) begin
        doneOk = 1'h1;
        st_d.sendIrq = 1'h1;
        st_d.sendLink = LW'(i);
        st_d.waitAck[i] = 1'h0;
      end
    end
    // Command step: one cycle, then the semaphore answers.
    if (st_q.fsm == LK_EXEC) begin
      st_d.fsm = LK_IDLE;
      st_d.sem = `LK_SEM_DONE;
      if (!cmdLegal) begin
        st_d.sem = `LK_SEM_REJECT;
      end else begin
        case (st_q.cmd)
          LK_CMD_OPEN: begin
            if (st_q.active[tgt] || dupDlci) begin
              st_d.faultIrq = 1'h1;
              st_d.faultArg = `LK_FAULT_ARG;
            end else if (!st_q.expanded && !freeFound) begin
              st_d.fullIrq = 1'h1;
            end else begin
              if (st_q.expanded) begin
                st_d.extWe = 1'h1;
                st_d.extDlci = st_q.cfgDlci[tgt];
                st_d.extLink = tgt;
              end else begin
                for (int j = NMATCH - 1; j >= 0; j--) begin
                  if (!st_q.msValid[j]) begin
                    st_d.msValid = st_q.msValid | (NMATCH'(1) << j);
                    st_d.msDlci[j] = st_q.cfgDlci[tgt];
                    st_d.msLink[j] = tgt;
                  end
                end
              end
              st_d.active[tgt] = 1'h1;
              st_d.halt[tgt] = 1'h0;
              st_d.ackBit[tgt] = 1'h0;
              st_d.txBit[tgt] = 1'h0;
              st_d.stopI[tgt] = 1'h0;
              st_d.pollOut[tgt] = 1'h0;
              st_d.peerQ[tgt] = 1'h0;
              st_d.lstate[tgt] = st_q.cfgRaw[tgt] ? LK_LS_RAW : LK_LS_NOTEI;
            end
          end
          LK_CMD_CLOSE: begin
            st_d.halt[tgt] = 1'h1;
            st_d.ackBit[tgt] = 1'h0;
            st_d.txBit[tgt] = 1'h0;
            if (iQueued[tgt]) begin
              st_d.closing[tgt] = 1'h1;
            end else begin
              st_d.active[tgt] = 1'h0;
            end
            if (st_q.expanded) begin
              st_d.extDel = 1'h1;
              st_d.extDlci = st_q.cfgDlci[tgt];
              st_d.extLink = tgt;
            end else begin
              for (int j = 0; j < NMATCH; j++) begin
                if (st_q.msValid[j] && (st_q.msLink[j] == tgt)) begin
                  st_d.msValid[j] = 1'h0;
                end
              end
            end
          end
          LK_CMD_REMOTE: begin
            if (!st_q.pollOut[tgt]) begin
              st_d.pollReq = 1'h1;
              st_d.pollLink = tgt;
              st_d.pollOut[tgt] = 1'h1;
            end
            st_d.peerQ[tgt] = 1'h1;
          end
          LK_CMD_SET_HOLD: st_d.hold[tgt] = 1'h1;
          LK_CMD_CLR_HOLD: begin
            st_d.hold[tgt] = 1'h0;
            st_d.starve[tgt] = 1'h0;
          end
          LK_CMD_STOP_I: begin
            st_d.stopI[tgt] = 1'h1;
            st_d.waitAck[tgt] = 1'h1;
            st_d.abortI = txIBusy && (txILink == tgt);
          end
          LK_CMD_STOP_XIDG: begin
            st_d.xidStop[0] = 1'h1;
            st_d.abortXid[0] = xidBusy[0];
          end
          LK_CMD_STOP_XID0: begin
            st_d.xidStop[1] = 1'h1;
            st_d.abortXid[1] = xidBusy[1];
          end
          default: st_d.sem = `LK_SEM_REJECT;
        endcase
      end
    end
    // Starvation is set after the command so that a same-cycle clear loses.
    if (rxStarve) begin
      st_d.starve[rxStarveLink] = 1'h1;
    end
    st_d.topLive = topOf(st_d.active);
    st_d.busyOut = st_d.hold | st_d.starve;
  end

  // State register; a low clock enable freezes everything.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.sem <= `LK_SEM_RESET;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Outputs taken straight from the state register.
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign pollFrameReq = st_q.pollReq;
  assign pollFrameLink = st_q.pollLink;
  assign abortIFrame = st_q.abortI;
  assign abortXidFrame = st_q.abortXid;
  assign txIStopped = st_q.stopI;
  assign xidStopped = st_q.xidStop;
  assign localBusy = st_q.busyOut;
  assign linkActive = st_q.active;
  assign mgmtFaultIrq = st_q.faultIrq;
  assign mgmtFaultArg = st_q.faultArg;
  assign matchFullIrq = st_q.fullIrq;
  assign peerDoneIrq = st_q.peerIrq;
  assign peerDoneLink = st_q.peerLink;
  assign sendDoneIrq = st_q.sendIrq;
  assign sendDoneLink = st_q.sendLink;
  assign extMatchWe = st_q.extWe;
  assign extMatchDel = st_q.extDel;
  assign extMatchDlci = st_q.extDlci;
  assign extMatchLink = st_q.extLink;
  assign topLiveLink = st_q.topLive;

  // Checks on the command step and the link events.
  a_sem_answer: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce) |=> (st_q.sem == `LK_SEM_DONE || st_q.sem == `LK_SEM_REJECT))
    else $error("semaphore did not answer after a command step");
  a_open_fault: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce && cmdLegal && st_q.cmd == LK_CMD_OPEN && dupDlci)
      |=> (mgmtFaultIrq && mgmtFaultArg == 24'h000000 && !extMatchWe))
    else $error("duplicate open did not raise a fault");
  a_open_state: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce && cmdLegal && st_q.cmd == LK_CMD_OPEN && !dupDlci &&
     !st_q.active[tgt] && (st_q.expanded || freeFound) && !st_q.cfgRaw[tgt])
      |=> (st_q.lstate[$past(tgt)] == LK_LS_NOTEI && linkActive[$past(tgt)] && extMatchWe == $past(st_q.expanded)))
    else $error("protocol open did not reach the no terminal id state");
  a_close_bits: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce && cmdLegal && st_q.cmd == LK_CMD_CLOSE)
      |=> (st_q.halt[$past(tgt)] && !st_q.ackBit[$past(tgt)] && !st_q.txBit[$past(tgt)]))
    else $error("close left the send state word wrong");
  a_poll_send: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce && cmdLegal && st_q.cmd == LK_CMD_REMOTE && !st_q.pollOut[tgt])
      |=> (pollFrameReq && pollFrameLink == $past(tgt) && st_q.peerQ[$past(tgt)]))
    else $error("query without poll sent no poll frame");
  a_poll_hold: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce && cmdLegal && st_q.cmd == LK_CMD_REMOTE && st_q.pollOut[tgt])
      |=> (!pollFrameReq && st_q.peerQ[$past(tgt)]))
    else $error("query with poll outstanding sent another frame");
  a_peer_done: assert property (@(posedge clock) disable iff (sys_rst)
    (ce && st_q.fsm == LK_IDLE && rxFrameValid && rxFrameFinal && st_q.pollOut[rxFrameLink])
      |=> (peerDoneIrq && !st_q.pollOut[peerDoneLink] && !st_q.peerQ[peerDoneLink]))
    else $error("final response did not finish the query");
  a_raw_reject: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce && st_q.cmd == LK_CMD_REMOTE && st_q.lstate[tgt] == LK_LS_RAW)
      |=> (st_q.sem == `LK_SEM_REJECT && !pollFrameReq))
    else $error("raw link accepted a query");
  a_hold_busy: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce && cmdLegal && st_q.cmd == LK_CMD_SET_HOLD) |=> localBusy[$past(tgt)])
    else $error("set hold did not force receive busy");
  a_stop_wait: assert property (@(posedge clock) disable iff (sys_rst)
    sendDoneIrq |-> |($past(unackedNone & st_q.waitAck) & (NLINK'(1) << sendDoneLink)))
    else $error("stop completion before all frames acknowledged");
  a_xid_abort: assert property (@(posedge clock) disable iff (sys_rst)
    (st_q.fsm == LK_EXEC && ce && st_q.cmd == LK_CMD_STOP_XID0 && xidBusy[1])
      |=> (abortXidFrame[1] && xidStopped[1]))
    else $error("queue zero stop did not abort the frame");
endmodule : lk_ext_cmd_unit
`default_nettype wire

// ===== dv/lk_far_model.sv
// Far-side model that answers each poll frame with one final response after a set lag.
`timescale 1ns/1ps
`default_nettype none
module lk_far_model #(
  parameter int LW = 4
) (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          pollFrameReq,
  input  wire logic [LW-1:0] pollFrameLink,
  input  wire logic [7:0]    lag,
  output logic               rxFrameValid,
  output logic               rxFrameFinal,
  output logic      [LW-1:0] rxFrameLink
);
  logic [7:0]    waitCnt;
  logic [LW-1:0] polledLink;
  // Counts the lag down; the link lines change every idle cycle so stale values are never trusted.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt <= 8'h00;
      polledLink <= '0;
      rxFrameValid <= 1'b0;
      rxFrameFinal <= 1'b0;
      rxFrameLink <= '0;
    end else if (pollFrameReq) begin
      waitCnt <= lag;
      polledLink <= pollFrameLink;
    end else if (waitCnt == 8'h01) begin
      waitCnt <= 8'h00;
      rxFrameValid <= 1'b1;
      rxFrameFinal <= 1'b1;
      rxFrameLink <= polledLink;
    end else begin
      waitCnt <= (waitCnt == 8'h00) ? 8'h00 : waitCnt - 8'h01;
      rxFrameValid <= 1'b0;
      rxFrameFinal <= 1'b0;
      rxFrameLink <= ~rxFrameLink;
    end
  end
endmodule : lk_far_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the link extension command unit.
`timescale 1ns/1ps
`default_nettype none
`include "lk_map.svh"
module testbench;
  import lk_pkg::*;
  logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr, errSeen;
  logic [7:0]  paddr, lag;
  logic [31:0] pwdata, prdata, rd;
  logic        rxFrameValid, rxFrameFinal, rxStarve, queueHeadTake, txIBusy, pollFrameReq, abortIFrame;
  logic        mgmtFaultIrq, matchFullIrq, peerDoneIrq, sendDoneIrq, extMatchWe;
  logic [3:0]  rxFrameLink, rxStarveLink, queueHeadLink, txILink, pollFrameLink, topLiveLink;
  logic [3:0]  peerDoneLink, sendDoneLink, extMatchLink;
  logic [1:0]  xidBusy, abortXidFrame, xidStopped;
  logic [15:0] iQueued, unackedNone, localBusy, linkActive, txIStopped;
  logic [23:0] faultArg;
  int          n_mismatch, checked, nPoll, nPeer, nFault, nFull, nAbortI, nAbortX, nSend, nExt, k;
  // The match store holds one pair so that opening a second link finds it full.
  lk_ext_cmd_unit #(.NMATCH(1)) dut_u (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxFrameValid(rxFrameValid), .rxFrameFinal(rxFrameFinal), .rxFrameLink(rxFrameLink),
    .rxStarve(rxStarve), .rxStarveLink(rxStarveLink), .queueHeadTake(queueHeadTake),
    .queueHeadLink(queueHeadLink), .iQueued(iQueued), .txIBusy(txIBusy), .txILink(txILink), .xidBusy(xidBusy),
    .unackedNone(unackedNone), .pollFrameReq(pollFrameReq), .pollFrameLink(pollFrameLink),
    .abortIFrame(abortIFrame), .abortXidFrame(abortXidFrame), .txIStopped(txIStopped),
    .xidStopped(xidStopped), .localBusy(localBusy), .linkActive(linkActive), .mgmtFaultIrq(mgmtFaultIrq),
    .mgmtFaultArg(faultArg), .matchFullIrq(matchFullIrq), .peerDoneIrq(peerDoneIrq), .peerDoneLink(peerDoneLink),
    .sendDoneIrq(sendDoneIrq), .sendDoneLink(sendDoneLink), .extMatchWe(extMatchWe), .extMatchDel(), .extMatchDlci(),
    .extMatchLink(extMatchLink), .topLiveLink(topLiveLink));
  lk_far_model #(.LW(4)) far_u (.clock(clock), .sys_rst(sys_rst), .pollFrameReq(pollFrameReq),
    .pollFrameLink(pollFrameLink), .lag(lag), .rxFrameValid(rxFrameValid), .rxFrameFinal(rxFrameFinal),
    .rxFrameLink(rxFrameLink));
  // Clock at 100 MHz.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Event pulses are counted mid-cycle, where they have settled.
  always @(negedge clock) begin
    if (!sys_rst) begin
      nPoll += pollFrameReq; nPeer += peerDoneIrq; nFault += mgmtFaultIrq; nFull += matchFullIrq;
      nAbortI += abortIFrame; nAbortX += 32'(abortXidFrame); nSend += sendDoneIrq; nExt += extMatchWe;
    end
  end
  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      give_verdict();
    end
    rd = prdata; errSeen = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic cfg(input logic [3:0] l, input logic [12:0] dlci, input logic raw);
    apb(1'b1, `LK_OFS_ARG, {28'h0, l});
    apb(1'b1, `LK_OFS_LCFG, {14'h0, 1'b1, raw, 3'h0, dlci});
  endtask : cfg
  // Issues a command and polls the semaphore until it leaves busy.
  task automatic cmd(input logic [7:0] code, input logic [3:0] l, input logic [7:0] exp);
    int n;
    apb(1'b1, `LK_OFS_ARG, {28'h0, l});
    apb(1'b1, `LK_OFS_CMD, {24'h0, code});
    n = 0;
    do begin
      apb(1'b0, `LK_OFS_SEM, 32'h0);
      n++;
    end while (rd[7:0] === `LK_SEM_BUSY && n < 20);
    chk(rd[7:0], exp);
  endtask : cmd
  // Watchdog.
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; lag = 8'h3C;
    rxStarve = 1'b0; rxStarveLink = 4'h0; queueHeadTake = 1'b0; queueHeadLink = 4'h0; iQueued = 16'h0;
    txIBusy = 1'b0; txILink = 4'h0; xidBusy = 2'h0; unackedNone = 16'h0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, `LK_OFS_SEM, 32'h0);
    chk(rd[7:0], 8'hFF);
    apb(1'b0, 8'hF0, 32'h0);
    chk(errSeen, 1'b1);
    cfg(4'h3, 13'h0123, 1'b0);
    cmd(LK_CMD_OPEN, 4'h3, 8'hFF);
    apb(1'b0, `LK_OFS_LSTAT, 32'h0);
    chk(rd[13:12], 2'h1);
    chk(linkActive[3], 1'b1);
    chk(topLiveLink, 4'h3);
    cmd(LK_CMD_OPEN, 4'h3, 8'hFF);
    chk(nFault, 1);
    chk(faultArg, 24'h000000);
    cfg(4'h4, 13'h0456, 1'b0);
    cmd(LK_CMD_OPEN, 4'h4, 8'hFF);
    chk(nFull, 1);
    chk(linkActive[4], 1'b0);
    apb(1'b1, `LK_OFS_MODE, 32'h1);
    cfg(4'h5, 13'h0789, 1'b1);
    cmd(LK_CMD_OPEN, 4'h5, 8'hFF);
    chk(nExt, 1);
    chk(extMatchLink, 4'h5);
    apb(1'b0, `LK_OFS_LSTAT, 32'h0);
    chk(rd[13:12], 2'h2);
    cmd(LK_CMD_REMOTE, 4'h5, `LK_SEM_REJECT);
    cmd(LK_CMD_SET_HOLD, 4'h5, 8'hFF);
    cmd(8'h6B, 4'h3, `LK_SEM_REJECT);
    cmd(LK_CMD_REMOTE, 4'h3, 8'hFF);
    cmd(LK_CMD_REMOTE, 4'h3, 8'hFF);
    chk(nPoll, 1);
    apb(1'b0, `LK_OFS_LSTAT, 32'h0);
    chk(rd[5:4], 2'h3);
    for (k = 0; k < 100 && nPeer == 0; k++) @(posedge clock);
    chk(nPeer, 1);
    chk(peerDoneLink, 4'h3);
    apb(1'b0, `LK_OFS_LSTAT, 32'h0);
    chk(rd[5:4], 2'h0);
    cmd(LK_CMD_SET_HOLD, 4'h3, 8'hFF);
    chk(localBusy[3], 1'b1);
    cmd(LK_CMD_CLR_HOLD, 4'h3, 8'hFF);
    chk(localBusy[3], 1'b0);
    @(posedge clock);
    rxStarveLink <= 4'h3; rxStarve <= 1'b1;
    @(posedge clock);
    rxStarve <= 1'b0;
    @(negedge clock);
    chk(localBusy[3], 1'b1);
    cmd(LK_CMD_CLR_HOLD, 4'h3, 8'hFF);
    chk(localBusy[3], 1'b0);
    txILink <= 4'h3; txIBusy <= 1'b1;
    cmd(LK_CMD_STOP_I, 4'h3, 8'hFF);
    chk(nAbortI, 1);
    chk(txIStopped[3], 1'b1);
    chk(nSend, 0);
    unackedNone[3] <= 1'b1; txIBusy <= 1'b0;
    for (k = 0; k < 20 && nSend == 0; k++) @(posedge clock);
    chk(nSend, 1);
    chk(sendDoneLink, 4'h3);
    xidBusy <= 2'h3;
    cmd(LK_CMD_STOP_XIDG, 4'h0, 8'hFF);
    cmd(LK_CMD_STOP_XID0, 4'h0, 8'hFF);
    chk(nAbortX, 3);
    chk(xidStopped, 2'h3);
    apb(1'b1, `LK_OFS_MODE, 32'h0);
    iQueued[3] <= 1'b1;
    cmd(LK_CMD_CLOSE, 4'h3, 8'hFF);
    apb(1'b0, `LK_OFS_LSTAT, 32'h0);
    chk(rd[3:0], 4'h3);
    queueHeadLink <= 4'h3; queueHeadTake <= 1'b1; iQueued[3] <= 1'b0;
    @(posedge clock);
    queueHeadTake <= 1'b0;
    repeat (2) @(negedge clock);
    chk(linkActive[3], 1'b0);
    cmd(LK_CMD_OPEN, 4'h4, 8'hFF);
    chk(linkActive[4], 1'b1);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
